// ### verilog/cir_pkg.sv
// Package with the register map, field layout and types of the card id block.
// Functional notes
// - Busy bit 31 low until power-up done.
// - Shared busy line acts as wired-AND.
// - Implement the 32-bit operating conditions register.
// - Bits 23:15 one; 14:8, reserved zero.
// - Bit 7 one only on low-voltage variant.
// - Provide 16-byte identity register with serial.
// - Identity register fixed, host writes ignored.
// - Identity fields at their fixed bit slices.
// - Checksum is CRC7, generator x^7+x^3+1.
// - Identity bit 0 always reads one.
// - Keep relative address for the session.
// - Revision is two BCD digits, major high.
package cir_pkg;

  // Register byte addresses on the Wishbone slave.
  localparam logic [7:0] ADR_OCR = 8'h00;
  localparam logic [7:0] ADR_CID0 = 8'h04;
  localparam logic [7:0] ADR_CID1 = 8'h08;
  localparam logic [7:0] ADR_CID2 = 8'h0C;
  localparam logic [7:0] ADR_CID3 = 8'h10;
  localparam logic [7:0] ADR_RCA = 8'h14;
  localparam logic [7:0] ADR_CTRL = 8'h18;
  localparam logic [7:0] ADR_STAT = 8'h1C;

  // Operating conditions register layout.
  localparam int OCR_BUSY_BIT = 31;
  localparam int OCR_LV_BIT = 7;
  localparam int OCR_HV_LSB = 15;
  localparam int OCR_HV_MSB = 23;
  localparam logic [8:0] OCR_HV_ONES = 9'h1FF;
  localparam logic [31:0] OCR_BASE = 32'h00FF8000;

  // Control and status bit positions.
  localparam int CTRL_PWR_BIT = 0;
  localparam int CTRL_LV_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_BUS_BIT = 0;
  localparam int STAT_PWR_BIT = 1;

  // Relative address width and its value after reset.
  localparam int RCA_W = 16;
  localparam logic [15:0] RCA_RESET = 16'h0000;

  // Checksum generator taps below x^7, and the fixed trailing bit.
  localparam logic [6:0] CRC_POLY = 7'h09;
  localparam logic [6:0] CRC_INIT = 7'h00;
  localparam logic CID_PAD = 1'b1;

  // Identity contents; the maker, application and name values are arbitrary.
  localparam logic [7:0] CID_MAKER = 8'h5A;
  localparam logic [15:0] CID_APP = 16'h1234;
  localparam logic [47:0] CID_NAME = 48'h44454D4F3031;
  localparam logic [7:0] CID_REV = 8'h10;
  localparam logic [31:0] CID_SERIAL = 32'h00000001;
  localparam logic [7:0] CID_DATE = 8'h11;
  localparam logic [3:0] BCD_MAX = 4'h9;

  // Identity register as stored, most significant field first.
  typedef struct packed {
    logic [7:0] maker;
    logic [15:0] app;
    logic [47:0] name;
    logic [7:0] rev;
    logic [31:0] serial;
    logic [7:0] date;
    logic [6:0] crc;
    logic pad;
  } cir_cid_t;

  // One Wishbone request as presented by the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } cir_wb_req_t;

  localparam logic [31:0] WB_ZERO = 32'h00000000;

endpackage

// ### verilog/cir_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ps
module cir_sync #(
  parameter int W = 1
) (
  // Clock and reset of the receiving domain.
  input wire logic clk,
  input wire logic rst_n,
  // Level from the other domain and its synchronised copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // First stage, read by the second stage only.
  logic [W-1:0] meta_q;

  // Both stages clear to zero under reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ### verilog/cir_crc7.sv
// Combinational CRC7 over the 120 message bits of the identity register.
`timescale 1ns/1ps
module cir_crc7
  import cir_pkg::*;
(
  // Message, most significant bit shifted in first.
  input wire logic [119:0] msg,
  // Remainder of the message times x^7 divided by the generator.
  output logic [6:0] crc
);

  // Shift each bit through the divider; the feedback applies the taps.
  always_comb begin
    logic fb;
    crc = CRC_INIT;
    fb = 1'b0;
    for (int i = 119; i >= 0; i--) begin
      fb = msg[i] ^ crc[6];
      crc = {crc[5:0], 1'b0};
      if (fb) begin
        crc = crc ^ CRC_POLY;
      end
    end
  end

endmodule

// ### verilog/cir_top.sv
// Card identity, operating conditions and relative address registers.
`timescale 1ns/1ps
module cir_top
  import cir_pkg::*;
(
  // System clock and asynchronous active-low reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Wishbone slave request.
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  // Wishbone slave answer.
  output logic WB_ACK_O,
  output logic [31:0] WB_DAT_O,
  // Link clock and the address assignment made by link logic.
  input wire logic LINK_CLK,
  input wire logic LINK_RCA_SET,
  input wire logic [15:0] LINK_RCA_VAL,
  // Open-drain busy line shared with other cards.
  input wire logic LINK_BUSY_I,
  output logic LINK_BUSY_O,
  output logic LINK_BUSY_OE
);

  // Request bundle gathered from the bus pins.
  cir_wb_req_t req;
  // Answer registers.
  logic ack_q;
  logic [31:0] dat_q;
  // Control: power-up finished and low-voltage variant.
  logic [1:0] ctrl_q;
  // Relative address held in the system domain.
  logic [15:0] rca_q;
  // Assembled register images.
  logic [31:0] ocr_w;
  cir_cid_t cid_w;
  logic [6:0] crc_w;
  logic [31:0] rd_d;
  // Crossing signals.
  logic bus_ready_s;
  logic rca_tog_s;
  logic rca_seen_q;
  logic rca_new;
  // Link domain state.
  logic [15:0] rca_l_q;
  logic rca_tog_l_q;
  logic pwr_l_s;
  logic busy_oe_q;
  logic busy_o_q;
  // Strobe that marks a request accepted this cycle.
  logic take;
  logic wr;

  // Bundle the pins into one request.
  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I,
                 sel: WB_SEL_I, adr: WB_ADR_I, dat: WB_DAT_I};
  assign take = req.cyc & req.stb & ~ack_q;
  assign wr = take & req.we;

  // Operating conditions: fixed voltage ranges, variant bit, busy bit.
  always_comb begin
    ocr_w = OCR_BASE;
    ocr_w[OCR_LV_BIT] = ctrl_q[CTRL_LV_BIT];
    ocr_w[OCR_BUSY_BIT] = ctrl_q[CTRL_PWR_BIT];
  end

  // Checksum over the 120 message bits above the checksum field.
  cir_crc7 u_crc (
    .msg({CID_MAKER, CID_APP, CID_NAME, CID_REV, CID_SERIAL, CID_DATE}),
    .crc(crc_w)
  );

  // Identity contents are constants; no write path reaches them.
  always_comb begin
    cid_w.maker = CID_MAKER;
    cid_w.app = CID_APP;
    cid_w.name = CID_NAME;
    cid_w.rev = CID_REV;
    cid_w.serial = CID_SERIAL;
    cid_w.date = CID_DATE;
    cid_w.crc = crc_w;
    cid_w.pad = CID_PAD;
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    if (req.adr == ADR_OCR) begin
      rd_d = ocr_w;
    end else if (req.adr == ADR_CID0) begin
      rd_d = cid_w[31:0];
    end else if (req.adr == ADR_CID1) begin
      rd_d = cid_w[63:32];
    end else if (req.adr == ADR_CID2) begin
      rd_d = cid_w[95:64];
    end else if (req.adr == ADR_CID3) begin
      rd_d = cid_w[127:96];
    end else if (req.adr == ADR_RCA) begin
      rd_d = {16'h0000, rca_q};
    end else if (req.adr == ADR_CTRL) begin
      rd_d = {30'h00000000, ctrl_q};
    end else if (req.adr == ADR_STAT) begin
      rd_d = WB_ZERO;
      rd_d[STAT_BUS_BIT] = bus_ready_s;
      rd_d[STAT_PWR_BIT] = ctrl_q[CTRL_PWR_BIT];
    end else begin
      rd_d = WB_ZERO;
    end
  end

  // Acknowledge every request one cycle after it appears.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  // Read data is captured with the acknowledge and held otherwise.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dat_q <= WB_ZERO;
    end else if (take) begin
      dat_q <= req.we ? WB_ZERO : rd_d;
    end
  end

  // Control register; only byte lane 0 carries its bits.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr && req.adr == ADR_CTRL && req.sel[0]) begin
      ctrl_q <= req.dat[1:0];
    end
  end

  // Combined level of the shared busy line into the system domain.
  cir_sync #(.W(1)) u_bus_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d(LINK_BUSY_I),
    .q(bus_ready_s)
  );

  // Address-assignment toggle from the link domain.
  cir_sync #(.W(1)) u_tog_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d(rca_tog_l_q),
    .q(rca_tog_s)
  );

  assign rca_new = rca_tog_s ^ rca_seen_q;

  // Remember the last toggle level that has been taken over.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rca_seen_q <= 1'b0;
    end else begin
      rca_seen_q <= rca_tog_s;
    end
  end

  // Take the link's stable address word when its toggle arrives.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rca_q <= RCA_RESET;
    end else if (rca_new) begin
      rca_q <= rca_l_q;
    end
  end

  // Link side: hold the assigned address and flip the toggle.
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rca_l_q <= RCA_RESET;
      rca_tog_l_q <= 1'b0;
    end else if (LINK_RCA_SET) begin
      rca_l_q <= LINK_RCA_VAL;
      rca_tog_l_q <= ~rca_tog_l_q;
    end
  end

  // Power-up status into the link domain.
  cir_sync #(.W(1)) u_pwr_sync (
    .clk(LINK_CLK),
    .rst_n(RST_N),
    .d(ctrl_q[CTRL_PWR_BIT]),
    .q(pwr_l_s)
  );

  // Pull the shared line low while busy, release it once powered up.
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_oe_q <= 1'b1;
      busy_o_q <= 1'b0;
    end else begin
      busy_oe_q <= ~pwr_l_s;
      busy_o_q <= 1'b0;
    end
  end

  // Drive the ports from their registers.
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign LINK_BUSY_O = busy_o_q;
  assign LINK_BUSY_OE = busy_oe_q;

  // The busy bit of a read answer follows the power-up control bit.
  a_ocr_busy_bit: assert property (@(posedge CLK) disable iff (!RST_N)
    take && !req.we && req.adr == ADR_OCR |=>
      WB_DAT_O[OCR_BUSY_BIT] == $past(ctrl_q[CTRL_PWR_BIT]))
    else $error("busy bit does not follow power-up state");

  // The voltage window bits read fixed ones and zeros.
  a_ocr_fixed_bits: assert property (@(posedge CLK) disable iff (!RST_N)
    ocr_w[OCR_HV_MSB:OCR_HV_LSB] == OCR_HV_ONES && ocr_w[14:8] == 7'h00 &&
    ocr_w[6:0] == 7'h00 && ocr_w[30:24] == 7'h00)
    else $error("voltage window bits wrong");

  // The low-voltage bit appears in a read answer as configured.
  a_ocr_lv_bit: assert property (@(posedge CLK) disable iff (!RST_N)
    take && !req.we && req.adr == ADR_OCR |=>
      WB_DAT_O[OCR_LV_BIT] == $past(ctrl_q[CTRL_LV_BIT]))
    else $error("low-voltage bit wrong");

  // The top identity word reads back the constants even right after a write.
  a_cid_read_only: assert property (@(posedge CLK) disable iff (!RST_N)
    take && !req.we && req.adr == ADR_CID3 |=>
      WB_DAT_O == {CID_MAKER, CID_APP, CID_NAME[47:40]})
    else $error("identity top word changed");

  // The low identity word carries date, checksum and the fixed one.
  a_cid_low_word: assert property (@(posedge CLK) disable iff (!RST_N)
    take && !req.we && req.adr == ADR_CID0 |=>
      WB_DAT_O[0] && WB_DAT_O[15:8] == CID_DATE && WB_DAT_O[7:1] == crc_w)
    else $error("identity low word wrong");

  // Both revision digits are valid decimal digits.
  a_rev_bcd_digits: assert property (@(posedge CLK) disable iff (!RST_N)
    cid_w.rev[7:4] <= BCD_MAX && cid_w.rev[3:0] <= BCD_MAX)
    else $error("revision is not two decimal digits");

  // A new address is held one cycle after its toggle is seen.
  a_rca_capture: assert property (@(posedge CLK) disable iff (!RST_N)
    rca_new |=> rca_q == $past(rca_l_q) && !rca_new)
    else $error("relative address not captured");

  // Each acknowledge lasts exactly one cycle.
  a_ack_one_cycle: assert property (@(posedge CLK) disable iff (!RST_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");

  // The shared line is only ever pulled low, never driven high.
  a_busy_drive_low: assert property (@(posedge LINK_CLK)
    disable iff (!RST_N)
    LINK_BUSY_O == 1'b0)
    else $error("busy line driven high");

  // The line is released once power-up is seen in the link domain.
  a_busy_release: assert property (@(posedge LINK_CLK)
    disable iff (!RST_N)
    pwr_l_s |=> !LINK_BUSY_OE)
    else $error("busy line not released");

  // While power-up is not finished the line stays pulled low.
  a_busy_hold: assert property (@(posedge LINK_CLK)
    disable iff (!RST_N)
    !pwr_l_s |=> LINK_BUSY_OE)
    else $error("busy line released too early");

  // Every accepted request is answered in the next cycle.
  a_ack_after_take: assert property (@(posedge CLK) disable iff (!RST_N)
    take |=> WB_ACK_O)
    else $error("request not acknowledged");

  // Read data stands unchanged until the next accepted request.
  a_dat_held: assert property (@(posedge CLK) disable iff (!RST_N)
    !take |=> WB_DAT_O == $past(WB_DAT_O))
    else $error("read data changed without a request");

  // Identity word one carries name, revision and serial slices.
  a_cid_mid_words: assert property (@(posedge CLK) disable iff (!RST_N)
    take && !req.we && req.adr == ADR_CID1 |=>
      WB_DAT_O == {CID_NAME[7:0], CID_REV, CID_SERIAL[31:16]})
    else $error("identity word one wrong");

  // Identity word two holds the middle of the product name.
  a_cid_name_word: assert property (@(posedge CLK) disable iff (!RST_N)
    take && !req.we && req.adr == ADR_CID2 |=>
      WB_DAT_O == CID_NAME[39:8])
    else $error("identity word two wrong");

  // The status word reports the synchronised shared busy level.
  a_stat_bus_bit: assert property (@(posedge CLK) disable iff (!RST_N)
    take && !req.we && req.adr == ADR_STAT |=>
      WB_DAT_O[STAT_BUS_BIT] == $past(bus_ready_s))
    else $error("status busy level wrong");

  // A control write with lane 0 enabled lands in the next cycle.
  a_ctrl_write: assert property (@(posedge CLK) disable iff (!RST_N)
    wr && req.adr == ADR_CTRL && req.sel[0] |=>
      ctrl_q == $past(req.dat[1:0]))
    else $error("control write lost");

endmodule

// ### tb/cir_host_model.sv
// Host-side model of the card bus: busy line and address assignment.
`timescale 1ns/1ps
module cir_host_model (
  // Link clock and the card's busy line drive.
  input wire logic link_clk,
  input wire logic busy_o,
  input wire logic busy_oe,
  // Second card on the line, high once it is ready.
  input wire logic other_rdy,
  // Resolved line level and the address assignment.
  output logic busy_line,
  output logic rca_set,
  output logic [15:0] rca_val
);
  // Pull-up level unless any card pulls the line low.
  assign busy_line = other_rdy & ~(busy_oe & ~busy_o);
  initial begin
    rca_set = 1'b0;
    rca_val = 16'h0000;
  end
  // Pulse one address for one link cycle, then scramble the value.
  task automatic assign_addr(input logic [15:0] v);
    @(posedge link_clk);
    rca_set <= 1'b1;
    rca_val <= v;
    @(posedge link_clk);
    rca_set <= 1'b0;
    rca_val <= ~v;
  endtask
  // Query the line until all cards report ready, within a bound.
  task automatic poll_ready(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge link_clk);
      ok = (busy_line === 1'b1);
    end
  endtask
endmodule

// ### tb/cir_top_tb.sv
// Self-checking bench for the card identity register block.
`timescale 1ns/1ps
module cir_top_tb;
  import cir_pkg::*;
  // Clocks, reset, bus drive and the bench's own register model.
  logic clk, lclk, rst_n, cyc, stb, we, other_rdy, ok, fb;
  logic ack, bsy_o, bsy_oe, bsy_line, rset;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [15:0] rval;
  logic [31:0] wdat, rdat, seed, rca_m, w;
  logic [1:0] ctrl_m;
  logic [6:0] crc;
  cir_cid_t cid_m;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int n_checks = 0;
  localparam logic [7:0] ADRS [8] = '{ADR_OCR, ADR_CID0, ADR_CID1,
    ADR_CID2, ADR_CID3, ADR_RCA, ADR_CTRL, 8'h20};

  cir_top DUT (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_ACK_O(ack), .WB_DAT_O(rdat), .LINK_CLK(lclk),
    .LINK_RCA_SET(rset), .LINK_RCA_VAL(rval), .LINK_BUSY_I(bsy_line),
    .LINK_BUSY_O(bsy_o), .LINK_BUSY_OE(bsy_oe));
  cir_host_model host (.link_clk(lclk), .busy_o(bsy_o), .busy_oe(bsy_oe),
    .other_rdy(other_rdy), .busy_line(bsy_line), .rca_set(rset),
    .rca_val(rval));

  // System clock at 8 ns and an unrelated link clock at 160 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #80 lclk = ~lclk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input string nm, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Xorshift source for random write data and addresses.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected read word for an address, from the bench's model.
  function automatic logic [31:0] exp_of(input logic [7:0] a);
    case (a)
      ADR_OCR: return OCR_BASE | {ctrl_m[0], 23'h0, ctrl_m[1], 7'h00};
      ADR_CID0: return cid_m[31:0];
      ADR_CID1: return cid_m[63:32];
      ADR_CID2: return cid_m[95:64];
      ADR_CID3: return cid_m[127:96];
      ADR_RCA: return rca_m;
      ADR_CTRL: return {30'h0, ctrl_m};
      default: return WB_ZERO;
    endcase
  endfunction

  // One classic Wishbone cycle; notes the expected data word first.
  task automatic wb(input logic w_en, input logic [7:0] a,
                    input logic [31:0] d, e);
    exp_q.push_back(e);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= a;
    wdat <= d;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1)
        break;
      if (i == 19) begin
        num_errors++;
        complete_run();
      end
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Reads one address against the model.
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, WB_ZERO, exp_of(a));
  endtask

  // Holds reset long enough for both clock domains.
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    repeat (2) @(posedge lclk);
    @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // Watches acks and compares each answer with the oldest note.
  always @(posedge clk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0)
        check("stray ack", 32'h1, 32'h0);
      else
        check("bus data", exp_q.pop_front(), rdat);
    end
  end

  initial begin
    {cyc, stb, we, adr, wdat, ctrl_m, rca_m} = '0;
    sel = 4'hF;
    rst_n = 1'b0;
    other_rdy = 1'b1;
    seed = 32'h0000F987;
    cid_m = '{CID_MAKER, CID_APP, CID_NAME, CID_REV, CID_SERIAL,
      CID_DATE, 7'h00, 1'b1};
    crc = 7'h00;
    for (int i = 127; i >= 8; i--) begin
      fb = cid_m[i] ^ crc[6];
      crc = {crc[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    cid_m.crc = crc;
    do_reset();
    // Every word except the status word, and one hole, right after reset.
    foreach (ADRS[i]) rd(ADRS[i]);
    // Random writes to read-only places must change nothing.
    foreach (ADRS[i])
      if (ADRS[i] != ADR_CTRL) wb(1'b1, ADRS[i], rnd(), WB_ZERO);
    foreach (ADRS[i]) rd(ADRS[i]);
    // Each variant and power-up setting shows in the conditions word.
    for (int v = 0; v < 4; v++) begin
      w = rnd();
      w[1:0] = v[1:0];
      wb(1'b1, ADR_CTRL, w, WB_ZERO);
      ctrl_m = v[1:0];
      rd(ADR_OCR);
    end
    // The busy line follows power-up, and another card can hold it low.
    wb(1'b1, ADR_CTRL, WB_ZERO, WB_ZERO);
    ctrl_m = 2'h0;
    other_rdy <= 1'b0;
    repeat (4) @(posedge lclk);
    check("busy oe", 32'h1, bsy_oe);
    wb(1'b1, ADR_CTRL, 32'h1, WB_ZERO);
    ctrl_m = 2'h1;
    repeat (4) @(posedge lclk);
    check("busy oe", 32'h0, bsy_oe);
    check("busy drive", 32'h0, bsy_o);
    repeat (4) @(posedge clk);
    wb(1'b0, ADR_STAT, WB_ZERO, 32'h2);
    other_rdy <= 1'b1;
    host.poll_ready(ok);
    check("ready poll", 32'h1, ok);
    repeat (4) @(posedge clk);
    wb(1'b0, ADR_STAT, WB_ZERO, 32'h3);
    // Two address assignments from the link side.
    repeat (2) begin
      w = rnd();
      rca_m = {16'h0, w[15:0]};
      host.assign_addr(w[15:0]);
      repeat (3) @(posedge lclk);
      repeat (6) @(posedge clk);
      rd(ADR_RCA);
    end
    // A second reset brings back the busy state and clears the address.
    do_reset();
    ctrl_m = CTRL_RESET;
    rca_m = {16'h0, RCA_RESET};
    rd(ADR_OCR);
    rd(ADR_RCA);
    repeat (3) @(posedge clk);
    check("notes left", 32'h0, exp_q.size());
    complete_run();
  end
endmodule
